// File: src/nrcfg_pkg.sv
// How it works
// - all three receiver configuration registers reload their defaults at reset and on the set-default command.
// - with one receive channel enabled, the channel pick bit enables AM when 0 and PM when 1.
// - with both channels enabled and manual selection on, the channel pick bit chooses the framing source.
// - the demodulator bit selects peak detector at 0 and mixer at 1, and the very-high-bitrate preset sets mixer.
// - the filter register carries a 3-bit low-pass field in bits 5:3 and a 3-bit zero setting in bits 2:0.
// - crc checking is skipped for frames after transmit-REQA or transmit-WUPA and while anticollision is set.
// - bit 7 of the agc/squelch register puts the receiver into low-power operation.
// - the LF bit selects differential input at 0 and split input at 1, and a separate bit applies LF to the input.
// - the agc mode bit limits adaptation to the first eight pulses at 0 and the whole receive period at 1.
// - the agc algorithm bit selects the preset algorithm at 0 and the reset algorithm at 1.
// - with dynamic squelch set, squelch starts 18.88 us after end of transmit and stops on mask timer expiry.
// - the mixer clock comes from the RF output at 0 and an internal signal at 1, always internal in single-ended mode.
// - each first-stage gain code gives full gain at 0, 2.5 dB cut per step for 1 to 6 and +5.5 dB boost at 7.
// - the limiter bit clips first and second stage outputs and is preset for active peer mode.
// - the peer gain force bit forces -6 dB and widest window, and clearing it requires a receiver restart.
package nrcfg_pkg;

	// ==========================================================
	// register indices and byte addresses
	localparam logic [7:0] IDX_FILT    = 8'h0a;
	localparam logic [7:0] IDX_AGC     = 8'h0b;
	localparam logic [7:0] IDX_GAIN    = 8'h0c;
	localparam logic [7:0] ADDR_FILT   = {IDX_FILT[5:0], 2'b00};
	localparam logic [7:0] ADDR_AGC    = {IDX_AGC[5:0], 2'b00};
	localparam logic [7:0] ADDR_GAIN   = {IDX_GAIN[5:0], 2'b00};
	localparam logic [7:0] ADDR_CMD    = 8'h40;
	localparam logic [7:0] ADDR_CTL    = 8'h44;
	localparam logic [7:0] ADDR_STAT   = 8'h48;

	// ==========================================================
	// reset values
	localparam logic [7:0] FILT_RST    = 8'h00;
	localparam logic [7:0] AGC_RST     = 8'h1a;
	localparam logic [7:0] GAIN_RST    = 8'hd8;
	localparam logic [5:0] CTL_RST     = 6'h00;

	// ==========================================================
	// field positions
	localparam int FILT_PICK   = 7;
	localparam int FILT_AMD    = 6;
	localparam int FILT_LP_HI  = 5;
	localparam int FILT_LP_LO  = 3;
	localparam int FILT_ZR_HI  = 2;
	localparam int AGC_LOWPWR  = 7;
	localparam int AGC_LFSPLIT = 6;
	localparam int AGC_LFEN    = 5;
	localparam int AGC_EN      = 4;
	localparam int AGC_MODE    = 3;
	localparam int AGC_ALG     = 2;
	localparam int AGC_SQDYN   = 1;
	localparam int AGC_MIXCLK  = 0;
	localparam int GAIN_AM_HI  = 7;
	localparam int GAIN_AM_LO  = 5;
	localparam int GAIN_PM_HI  = 4;
	localparam int GAIN_PM_LO  = 2;
	localparam int GAIN_LIM    = 1;
	localparam int GAIN_FORCE  = 0;
	// command bits (write one to fire)
	localparam int CMD_DEFAULT = 0;
	localparam int CMD_REQA    = 1;
	localparam int CMD_WUPA    = 2;
	localparam int CMD_PRESET  = 3;
	localparam int CMD_RESTART = 4;
	// control bits
	localparam int CTL_SINGLE  = 0;
	localparam int CTL_MANUAL  = 1;
	localparam int CTL_ANTICOL = 2;
	localparam int CTL_SE_MODE = 3;
	localparam int CTL_FAST_RATE = 4;
	localparam int CTL_PEER    = 5;

	// ==========================================================
	// timing and gain steps (half-dB units)
	localparam int unsigned CLK_NS      = 40;
	localparam int unsigned SQ_DELAY_NS = 18880;
	localparam int unsigned SQ_DELAY_CYC = (SQ_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [8:0]  SQ_LOAD     = 9'(SQ_DELAY_CYC - 1);
	localparam logic signed [7:0] GAIN_STEP_HDB  = 8'sh05;
	localparam logic signed [7:0] GAIN_BOOST_HDB = 8'sh0b;

	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00,
		SQ_WAIT = 2'b01,
		SQ_ON   = 2'b10
	} nrcfg_sq_t;

	typedef struct packed {
		logic        en;
		logic [7:0]  addr;
		logic [31:0] data;
	} nrcfg_wr_t;

	typedef struct packed {
		logic              am_en;
		logic              pm_en;
		logic              framing_pm;
		logic              amd_mixer;
		logic [2:0]        lowpass;
		logic [2:0]        zero_set;
		logic              low_power;
		logic              lf_split;
		logic              lf_to_rx;
		logic              agc_en;
		logic              agc_full;
		logic              agc_reset_alg;
		logic              mix_clk_int;
		logic              limiter;
		logic              peer_gain_force;
		logic signed [7:0] am_gain_hdb;
		logic signed [7:0] pm_gain_hdb;
	} nrcfg_rx_ctl_t;

endpackage : nrcfg_pkg

// File: src/nrcfg_gain_dec.sv
`timescale 1ns/10ps
// ==========================================================
// first-stage gain decoder, result in half-dB steps
module nrcfg_gain_dec (
	// code in
	input  wire logic [2:0]        code,
	// gain out
	output logic signed [7:0]      gain_hdb
);

	always_comb begin
		case (code)
			3'h0: gain_hdb = 8'sh00;
			3'h7: gain_hdb = nrcfg_pkg::GAIN_BOOST_HDB;
			default: gain_hdb = 8'(-(nrcfg_pkg::GAIN_STEP_HDB * $signed({5'h00, code})));
		endcase
	end

endmodule : nrcfg_gain_dec

// File: src/nrcfg_ahb_port.sv
`timescale 1ns/10ps
// ==========================================================
// ahb-lite slave front end, zero wait states
module nrcfg_ahb_port (
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	// ahb-lite
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	// register side
	output nrcfg_pkg::nrcfg_wr_t      wr,
	output logic [7:0]                rd_addr,
	input  wire logic [31:0]          rd_data
);

	logic       wpend_r;
	logic [7:0] waddr_r;
	logic       acc;

	assign acc       = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign rd_addr   = haddr[7:0];
	assign wr        = '{en: wpend_r, addr: waddr_r, data: hwdata};

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wpend_r <= 1'b0;
			waddr_r <= 8'h00;
		end else begin
			wpend_r <= acc & hwrite;
			if (acc)
				waddr_r <= haddr[7:0];
		end
	end

	// rd_data is built from next-state values, so a read right after a write sees it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			hrdata <= 32'h0000_0000;
		else if (acc & ~hwrite)
			hrdata <= rd_data;
	end

endmodule : nrcfg_ahb_port

// File: src/nrcfg_top.sv
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module nrcfg_top (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	// ahb-lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	// receive path events, same clock domain
	input  wire logic                  tx_end,
	input  wire logic                  mask_rx_expired,
	input  wire logic                  rx_frame_end,
	input  wire logic                  auto_pick_pm,
	// analog receiver control
	output nrcfg_pkg::nrcfg_rx_ctl_t   rx_ctl,
	output logic                       squelch_on,
	output logic                       crc_skip,
	output logic                       rx_restart
);

	// ==========================================================
	// bus front end
	nrcfg_pkg::nrcfg_wr_t wr;
	logic [7:0]           rd_addr;
	logic [31:0]          rd_data;

	nrcfg_ahb_port u_port (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.wr        (wr),
		.rd_addr   (rd_addr),
		.rd_data   (rd_data)
	);

	// ==========================================================
	// register file
	logic [7:0] filt_r;
	logic [7:0] filt_nxt;
	logic [7:0] agc_r;
	logic [7:0] agc_nxt;
	logic [7:0] gain_r;
	logic [7:0] gain_nxt;
	logic [5:0] ctl_r;
	logic [5:0] ctl_nxt;
	logic       wr_filt;
	logic       wr_agc;
	logic       wr_gain;
	logic       wr_ctl;
	logic       wr_cmd;
	logic [4:0] cmd;

	assign wr_filt = wr.en && wr.addr == nrcfg_pkg::ADDR_FILT;
	assign wr_agc  = wr.en && wr.addr == nrcfg_pkg::ADDR_AGC;
	assign wr_gain = wr.en && wr.addr == nrcfg_pkg::ADDR_GAIN;
	assign wr_ctl  = wr.en && wr.addr == nrcfg_pkg::ADDR_CTL;
	assign wr_cmd  = wr.en && wr.addr == nrcfg_pkg::ADDR_CMD;
	assign cmd     = wr_cmd ? wr.data[4:0] : 5'h00;

	always_comb begin
		filt_nxt = filt_r;
		agc_nxt  = agc_r;
		gain_nxt = gain_r;
		ctl_nxt  = ctl_r;
		if (wr_filt)
			filt_nxt = wr.data[7:0];
		if (wr_agc)
			agc_nxt = wr.data[7:0];
		if (wr_gain)
			gain_nxt = wr.data[7:0];
		if (wr_ctl)
			ctl_nxt = wr.data[5:0];
		// preset follows the mode bits already in the control register
		if (cmd[nrcfg_pkg::CMD_PRESET]) begin
			if (ctl_r[nrcfg_pkg::CTL_FAST_RATE])
				filt_nxt[nrcfg_pkg::FILT_AMD] = 1'b1;
			if (ctl_r[nrcfg_pkg::CTL_PEER]) begin
				gain_nxt[nrcfg_pkg::GAIN_LIM]   = 1'b1;
				gain_nxt[nrcfg_pkg::GAIN_FORCE] = 1'b1;
			end
		end
		if (cmd[nrcfg_pkg::CMD_DEFAULT]) begin
			filt_nxt = nrcfg_pkg::FILT_RST;
			agc_nxt  = nrcfg_pkg::AGC_RST;
			gain_nxt = nrcfg_pkg::GAIN_RST;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			filt_r <= nrcfg_pkg::FILT_RST;
			agc_r  <= nrcfg_pkg::AGC_RST;
			gain_r <= nrcfg_pkg::GAIN_RST;
			ctl_r  <= nrcfg_pkg::CTL_RST;
		end else begin
			filt_r <= filt_nxt;
			agc_r  <= agc_nxt;
			gain_r <= gain_nxt;
			ctl_r  <= ctl_nxt;
		end
	end

	// ==========================================================
	// receiver restart after leaving forced peer gain
	logic restart_pend_r;
	logic force_cleared;

	assign force_cleared = gain_r[nrcfg_pkg::GAIN_FORCE] & ~gain_nxt[nrcfg_pkg::GAIN_FORCE];

	// set wins over the restart command in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			restart_pend_r <= 1'b0;
		else if (force_cleared)
			restart_pend_r <= 1'b1;
		else if (cmd[nrcfg_pkg::CMD_RESTART])
			restart_pend_r <= 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rx_restart <= 1'b0;
		else
			rx_restart <= cmd[nrcfg_pkg::CMD_RESTART];
	end

	// ==========================================================
	// crc skip after short frames
	logic crc_frame_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			crc_frame_r <= 1'b0;
		else if (cmd[nrcfg_pkg::CMD_REQA] | cmd[nrcfg_pkg::CMD_WUPA])
			crc_frame_r <= 1'b1;
		else if (rx_frame_end)
			crc_frame_r <= 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			crc_skip <= 1'b0;
		else
			crc_skip <= crc_frame_r | ctl_r[nrcfg_pkg::CTL_ANTICOL];
	end

	// ==========================================================
	// dynamic squelch
	nrcfg_pkg::nrcfg_sq_t sq_state_r;
	logic [8:0]           sq_cnt_r;

	// mask expiry ends the window even before squelch has started
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sq_state_r <= nrcfg_pkg::SQ_IDLE;
			sq_cnt_r   <= 9'h000;
		end else begin
			case (sq_state_r)
				nrcfg_pkg::SQ_IDLE: begin
					if (tx_end && agc_r[nrcfg_pkg::AGC_SQDYN] && !mask_rx_expired) begin
						sq_state_r <= nrcfg_pkg::SQ_WAIT;
						sq_cnt_r   <= nrcfg_pkg::SQ_LOAD;
					end
				end
				nrcfg_pkg::SQ_WAIT: begin
					if (mask_rx_expired)
						sq_state_r <= nrcfg_pkg::SQ_IDLE;
					else if (sq_cnt_r == 9'h000)
						sq_state_r <= nrcfg_pkg::SQ_ON;
					else
						sq_cnt_r <= sq_cnt_r - 9'h001;
				end
				nrcfg_pkg::SQ_ON: begin
					if (mask_rx_expired)
						sq_state_r <= nrcfg_pkg::SQ_IDLE;
				end
				default: sq_state_r <= nrcfg_pkg::SQ_IDLE;
			endcase
		end
	end

	assign squelch_on = sq_state_r == nrcfg_pkg::SQ_ON;

	// ==========================================================
	// analog control bundle
	logic signed [7:0]        am_gain;
	logic signed [7:0]        pm_gain;
	nrcfg_pkg::nrcfg_rx_ctl_t ctl_c;
	logic                     pick_pm;

	nrcfg_gain_dec u_am_gain (
		.code     (gain_r[nrcfg_pkg::GAIN_AM_HI:nrcfg_pkg::GAIN_AM_LO]),
		.gain_hdb (am_gain)
	);

	nrcfg_gain_dec u_pm_gain (
		.code     (gain_r[nrcfg_pkg::GAIN_PM_HI:nrcfg_pkg::GAIN_PM_LO]),
		.gain_hdb (pm_gain)
	);

	assign pick_pm = filt_r[nrcfg_pkg::FILT_PICK];

	always_comb begin
		ctl_c.am_en = ~ctl_r[nrcfg_pkg::CTL_SINGLE] | ~pick_pm;
		ctl_c.pm_en = ~ctl_r[nrcfg_pkg::CTL_SINGLE] | pick_pm;
		if (ctl_r[nrcfg_pkg::CTL_SINGLE] | ctl_r[nrcfg_pkg::CTL_MANUAL])
			ctl_c.framing_pm = pick_pm;
		else
			ctl_c.framing_pm = auto_pick_pm;
		ctl_c.amd_mixer       = filt_r[nrcfg_pkg::FILT_AMD];
		ctl_c.lowpass         = filt_r[nrcfg_pkg::FILT_LP_HI:nrcfg_pkg::FILT_LP_LO];
		ctl_c.zero_set        = filt_r[nrcfg_pkg::FILT_ZR_HI:0];
		ctl_c.low_power       = agc_r[nrcfg_pkg::AGC_LOWPWR];
		ctl_c.lf_split        = agc_r[nrcfg_pkg::AGC_LFSPLIT];
		ctl_c.lf_to_rx        = agc_r[nrcfg_pkg::AGC_LFEN];
		ctl_c.agc_en          = agc_r[nrcfg_pkg::AGC_EN];
		ctl_c.agc_full        = agc_r[nrcfg_pkg::AGC_MODE];
		ctl_c.agc_reset_alg   = agc_r[nrcfg_pkg::AGC_ALG];
		ctl_c.mix_clk_int     = agc_r[nrcfg_pkg::AGC_MIXCLK] | ctl_r[nrcfg_pkg::CTL_SE_MODE];
		ctl_c.limiter         = gain_r[nrcfg_pkg::GAIN_LIM];
		ctl_c.peer_gain_force = gain_r[nrcfg_pkg::GAIN_FORCE];
		ctl_c.am_gain_hdb     = am_gain;
		ctl_c.pm_gain_hdb     = pm_gain;
	end

	// registered so the analog side never sees decode glitches
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rx_ctl <= '0;
		else
			rx_ctl <= ctl_c;
	end

	// ==========================================================
	// read mux, register words from next-state values, status word from current values
	always_comb begin
		case (rd_addr)
			nrcfg_pkg::ADDR_FILT: rd_data = {24'h000000, filt_nxt};
			nrcfg_pkg::ADDR_AGC:  rd_data = {24'h000000, agc_nxt};
			nrcfg_pkg::ADDR_GAIN: rd_data = {24'h000000, gain_nxt};
			nrcfg_pkg::ADDR_CTL:  rd_data = {26'h0000000, ctl_nxt};
			nrcfg_pkg::ADDR_STAT: rd_data = {28'h0000000, ctl_c.framing_pm, restart_pend_r, crc_skip, squelch_on};
			default:              rd_data = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// checks
	a_default_reload: assert property (@(posedge mclk) disable iff (!rst_n)
		cmd[nrcfg_pkg::CMD_DEFAULT] |=> filt_r == nrcfg_pkg::FILT_RST && agc_r == nrcfg_pkg::AGC_RST
			&& gain_r == nrcfg_pkg::GAIN_RST)
		else $error("registers not back at defaults after set-default");

	a_single_pick: assert property (@(posedge mclk) disable iff (!rst_n)
		ctl_r[nrcfg_pkg::CTL_SINGLE] |=> rx_ctl.pm_en == $past(pick_pm) && rx_ctl.am_en == !$past(pick_pm))
		else $error("single channel enable does not follow channel pick");

	a_manual_framing: assert property (@(posedge mclk) disable iff (!rst_n)
		!ctl_r[nrcfg_pkg::CTL_SINGLE] && ctl_r[nrcfg_pkg::CTL_MANUAL]
			|=> rx_ctl.am_en && rx_ctl.pm_en && rx_ctl.framing_pm == $past(pick_pm))
		else $error("manual framing source wrong");

	a_fast_mixer: assert property (@(posedge mclk) disable iff (!rst_n)
		cmd[nrcfg_pkg::CMD_PRESET] && !cmd[nrcfg_pkg::CMD_DEFAULT] && ctl_r[nrcfg_pkg::CTL_FAST_RATE]
			|=> filt_r[nrcfg_pkg::FILT_AMD] ##1 rx_ctl.amd_mixer)
		else $error("fast rate preset did not select mixer");

	a_crc_skip: assert property (@(posedge mclk) disable iff (!rst_n)
		(cmd[nrcfg_pkg::CMD_REQA] || cmd[nrcfg_pkg::CMD_WUPA]) |=> ##1 crc_skip)
		else $error("crc skip not raised after short frame command");

	a_squelch_start: assert property (@(posedge mclk) disable iff (!rst_n)
		sq_state_r == nrcfg_pkg::SQ_IDLE && tx_end && agc_r[nrcfg_pkg::AGC_SQDYN] && !mask_rx_expired
			|=> sq_state_r == nrcfg_pkg::SQ_WAIT && sq_cnt_r == nrcfg_pkg::SQ_LOAD && !squelch_on)
		else $error("squelch delay not started correctly");

	a_squelch_stop: assert property (@(posedge mclk) disable iff (!rst_n)
		squelch_on && mask_rx_expired |=> !squelch_on)
		else $error("squelch not stopped by mask timer");

	a_mixer_clock: assert property (@(posedge mclk) disable iff (!rst_n)
		ctl_r[nrcfg_pkg::CTL_SE_MODE] |=> rx_ctl.mix_clk_int)
		else $error("single-ended mode did not force internal mixer clock");

	a_gain_boost: assert property (@(posedge mclk) disable iff (!rst_n)
		gain_r[nrcfg_pkg::GAIN_AM_HI:nrcfg_pkg::GAIN_AM_LO] == 3'h7 |=> rx_ctl.am_gain_hdb == 8'sh0b)
		else $error("am boost code not decoded to +5.5 dB");

	a_restart_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		force_cleared |=> restart_pend_r [*2])
		else $error("restart need not flagged after clearing forced gain");

	a_write_whole: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_gain |=> gain_r == $past(wr.data[7:0]))
		else $error("gain register write not taken whole");

endmodule : nrcfg_top

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	// ==========================================================
	// clock, reset and bus signals
	logic                     mclk;
	logic                     rst_n;
	logic                     hsel;
	logic [31:0]              haddr;
	logic [1:0]               htrans;
	logic                     hwrite;
	logic [31:0]              hwdata;
	logic                     hready;
	logic                     hreadyout;
	logic                     hresp;
	logic [31:0]              hrdata;
	logic [2:0]               ev;
	logic                     auto_pm;
	nrcfg_pkg::nrcfg_rx_ctl_t rx_ctl;
	logic                     squelch_on;
	logic                     crc_skip;
	logic                     rx_restart;
	int                       miscompares;
	int                       checked;
	int                       n_restart;
	logic [31:0]              rd;
	int                       base;

	// the single slave drives the bus ready
	assign hready = hreadyout;

	nrcfg_top uut (
		.mclk            (mclk),
		.rst_n           (rst_n),
		.hsel            (hsel),
		.haddr           (haddr),
		.htrans          (htrans),
		.hwrite          (hwrite),
		.hsize           (3'h2),
		.hwdata          (hwdata),
		.hready          (hready),
		.hreadyout       (hreadyout),
		.hresp           (hresp),
		.hrdata          (hrdata),
		.tx_end          (ev[0]),
		.mask_rx_expired (ev[1]),
		.rx_frame_end    (ev[2]),
		.auto_pick_pm    (auto_pm),
		.rx_ctl          (rx_ctl),
		.squelch_on      (squelch_on),
		.crc_skip        (crc_skip),
		.rx_restart      (rx_restart)
	);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// restart is a one-cycle pulse, so it is counted rather than sampled once
	always @(posedge mclk) begin
		if (rx_restart === 1'b1) begin
			n_restart <= n_restart + 1;
		end
	end

	// ==========================================================
	// reporting
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic wrap_up;
		if (miscompares == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up

	// ==========================================================
	// ahb-lite single transfers, master holds each phase until hready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= w ? d : 32'h00000000;
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(what, e, rd);
	endtask : rd_chk

	// lets the registered receiver controls follow a register change
	task automatic settle;
		repeat (3) @(posedge mclk);
	endtask : settle

	task automatic pulse(input int k);
		ev[k] <= 1'b1;
		@(posedge mclk);
		ev[k] <= 1'b0;
	endtask : pulse

	// first-stage gain in half-dB steps: 2.5 dB cut per step, boost 5.5 dB at the top code
	function automatic logic [7:0] gain_exp(input int c);
		if (c == 0) begin
			return 8'h00;
		end else if (c == 7) begin
			return 8'h0b;
		end
		return 8'(-5 * c);
	endfunction : gain_exp

	// ==========================================================
	// watchdog, the run needs about 1200 cycles
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		wrap_up();
	end

	// ==========================================================
	// tests
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		ev = 3'h0;
		auto_pm = 1'b0;
		miscompares = 0;
		checked = 0;
		n_restart = 0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd_chk("filt_rst", nrcfg_pkg::ADDR_FILT, 32'h00);
		rd_chk("agc_rst", nrcfg_pkg::ADDR_AGC, 32'h1a);
		rd_chk("gain_rst", nrcfg_pkg::ADDR_GAIN, 32'hd8);
		rd_chk("unmapped", 8'h3c, 32'h0);
		chk("agc_dflt", 32'h3, {30'h0, rx_ctl.agc_en, rx_ctl.agc_full});
		chk("am_gain_dflt", {24'h0, gain_exp(6)}, {24'h0, rx_ctl.am_gain_hdb});
		// filter fields and demodulator type
		wr(nrcfg_pkg::ADDR_FILT, 32'h2d);
		rd_chk("filt_rb", nrcfg_pkg::ADDR_FILT, 32'h2d);
		settle();
		chk("filt_fields", 32'h2d, {26'h0, rx_ctl.lowpass, rx_ctl.zero_set});
		chk("amd_peak", 32'h0, {31'h0, rx_ctl.amd_mixer});
		wr(nrcfg_pkg::ADDR_FILT, 32'h40);
		settle();
		chk("amd_mixer", 32'h1, {31'h0, rx_ctl.amd_mixer});
		// agc/squelch register fields in both polarities
		wr(nrcfg_pkg::ADDR_AGC, 32'he5);
		settle();
		chk("agc_e5", 32'h73, {25'h0, rx_ctl.low_power, rx_ctl.lf_split, rx_ctl.lf_to_rx, rx_ctl.agc_en,
			rx_ctl.agc_full, rx_ctl.agc_reset_alg, rx_ctl.mix_clk_int});
		wr(nrcfg_pkg::ADDR_AGC, 32'h1a);
		settle();
		chk("agc_1a", 32'h0c, {25'h0, rx_ctl.low_power, rx_ctl.lf_split, rx_ctl.lf_to_rx, rx_ctl.agc_en,
			rx_ctl.agc_full, rx_ctl.agc_reset_alg, rx_ctl.mix_clk_int});
		wr(nrcfg_pkg::ADDR_CTL, 32'h08);
		settle();
		chk("mixclk_single_ended", 32'h1, {31'h0, rx_ctl.mix_clk_int});
		// channel pick: single channel, then manual, then automatic
		for (int p = 0; p < 2; p++) begin
			wr(nrcfg_pkg::ADDR_CTL, 32'h01);
			wr(nrcfg_pkg::ADDR_FILT, {24'h0, p[0], 7'h0});
			settle();
			chk("single_en", p ? 32'h1 : 32'h2, {30'h0, rx_ctl.am_en, rx_ctl.pm_en});
			wr(nrcfg_pkg::ADDR_CTL, 32'h02);
			settle();
			chk("manual_pick", {29'h0, 2'b11, p[0]}, {29'h0, rx_ctl.am_en, rx_ctl.pm_en, rx_ctl.framing_pm});
		end
		wr(nrcfg_pkg::ADDR_CTL, 32'h00);
		wr(nrcfg_pkg::ADDR_FILT, 32'h00);
		auto_pm <= 1'b1;
		settle();
		chk("auto_pick", 32'h1, {31'h0, rx_ctl.framing_pm});
		// every first-stage gain code on both channels
		for (int c = 0; c < 8; c++) begin
			wr(nrcfg_pkg::ADDR_GAIN, {24'h0, c[2:0], 3'(7 - c), 2'b00});
			rd_chk("gain_rb", nrcfg_pkg::ADDR_GAIN, {24'h0, c[2:0], 3'(7 - c), 2'b00});
			settle();
			chk("am_gain", {24'h0, gain_exp(c)}, {24'h0, rx_ctl.am_gain_hdb});
			chk("pm_gain", {24'h0, gain_exp(7 - c)}, {24'h0, rx_ctl.pm_gain_hdb});
		end
		// limiter, forced gain and the restart it demands once cleared
		wr(nrcfg_pkg::ADDR_GAIN, 32'h03);
		settle();
		chk("lim_force", 32'h3, {30'h0, rx_ctl.limiter, rx_ctl.peer_gain_force});
		wr(nrcfg_pkg::ADDR_GAIN, 32'h00);
		rd_chk("restart_pending", nrcfg_pkg::ADDR_STAT, 32'h0c);
		base = n_restart;
		wr(nrcfg_pkg::ADDR_CMD, 32'h10);
		settle();
		chk("restart_pulses", 32'(base + 1), 32'(n_restart));
		rd_chk("restart_done", nrcfg_pkg::ADDR_STAT, 32'h08);
		// analog preset in very-high-bitrate peer mode
		wr(nrcfg_pkg::ADDR_CTL, 32'h30);
		wr(nrcfg_pkg::ADDR_FILT, 32'h00);
		wr(nrcfg_pkg::ADDR_CMD, 32'h08);
		rd_chk("preset_mixer", nrcfg_pkg::ADDR_FILT, 32'h40);
		rd_chk("preset_lim", nrcfg_pkg::ADDR_GAIN, 32'h03);
		wr(nrcfg_pkg::ADDR_CTL, 32'h00);
		// set-default command restores all three registers
		wr(nrcfg_pkg::ADDR_FILT, 32'hff);
		wr(nrcfg_pkg::ADDR_AGC, 32'h00);
		wr(nrcfg_pkg::ADDR_GAIN, 32'h00);
		wr(nrcfg_pkg::ADDR_CMD, 32'h01);
		rd_chk("filt_dflt", nrcfg_pkg::ADDR_FILT, 32'h00);
		rd_chk("agc_dflt_cmd", nrcfg_pkg::ADDR_AGC, 32'h1a);
		rd_chk("gain_dflt_cmd", nrcfg_pkg::ADDR_GAIN, 32'hd8);
		// crc skip after each short-frame command and during anticollision
		for (int k = 1; k < 3; k++) begin
			wr(nrcfg_pkg::ADDR_CMD, 32'(1 << k));
			settle();
			chk("crc_skip_on", 32'h1, {31'h0, crc_skip});
			pulse(2);
			settle();
			chk("crc_skip_off", 32'h0, {31'h0, crc_skip});
		end
		wr(nrcfg_pkg::ADDR_CTL, 32'h04);
		settle();
		chk("crc_skip_anticol", 32'h1, {31'h0, crc_skip});
		wr(nrcfg_pkg::ADDR_CTL, 32'h00);
		settle();
		chk("crc_skip_clear", 32'h0, {31'h0, crc_skip});
		// dynamic squelch: 18.88 us is 472 cycles after end of transmit
		pulse(0);
		repeat (471) @(posedge mclk);
		chk("squelch_early", 32'h0, {31'h0, squelch_on});
		repeat (2) @(posedge mclk);
		chk("squelch_on", 32'h1, {31'h0, squelch_on});
		pulse(1);
		settle();
		chk("squelch_off", 32'h0, {31'h0, squelch_on});
		wr(nrcfg_pkg::ADDR_AGC, 32'h18);
		pulse(0);
		repeat (500) @(posedge mclk);
		chk("squelch_disabled", 32'h0, {31'h0, squelch_on});
		wrap_up();
	end
endmodule : tb_top
